// ===== enhanced_serial_if_core.sv
// Register file, baud generator, transmitter and receiver of the serial interface.
`timescale 1ns/1ps
`default_nettype none
module enhanced_serial_if_core #(
  parameter int DIV_W = 12
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Baud source, one-cycle enables from the two clock sources.
  input wire logic baudSrcSelect,
  input wire logic altTickIn,
  // Serial line.
  input wire logic rxdIn,
  output logic txdOut,
  // Interrupts.
  output logic errIrq,
  output logic irq
);
  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0] presc_q, ctrl1_q, ctrl2_q, baud_q, rdata_q;
  logic [5:0] irqEn_q;
  logic tx9_q, rx9_q;
  logic [7:0] rxData_q, txData_q;
  logic txe_q, tc_q, rxf_q, idle_q, or_q, nf_q, fe_q, pe_q;
  logic [2:0] evt_q, evtEn_q;

  logic wrCtrl3, wrData, rdData, rdStatus1, wrClr;
  assign wrCtrl3 = regWr && regAddr == enhanced_serial_if_pkg::ADDR_CTRL3;
  assign wrData = regWr && regAddr == enhanced_serial_if_pkg::ADDR_DATA;
  assign rdData = regRd && regAddr == enhanced_serial_if_pkg::ADDR_DATA;
  assign rdStatus1 = regRd && regAddr == enhanced_serial_if_pkg::ADDR_STATUS1;
  assign wrClr = regWr && regAddr == enhanced_serial_if_pkg::ADDR_EVT_CLEAR;

  logic nine;
  assign nine = ctrl1_q[enhanced_serial_if_pkg::C1_NINE];

  // ---------------------------------------------------------------------------
  // Baud generator
  // ---------------------------------------------------------------------------
  // Both sources are enables in the one clock domain; the divisor comes from the baud and prescaler registers.
  logic srcTick, tick16;
  logic [DIV_W-1:0] divCnt_q, divisor;
  assign srcTick = baudSrcSelect ? altTickIn : 1'b1;
  assign divisor = DIV_W'({baud_q[2:0], presc_q[4:0]}) + DIV_W'(1);
  assign tick16 = srcTick && divCnt_q == DIV_W'(0);
  always_ff @(posedge clk) begin
    if (rst) divCnt_q <= '0;
    else if (srcTick) begin
      divCnt_q <= (divCnt_q == DIV_W'(0)) ? divisor - DIV_W'(1) : divCnt_q - DIV_W'(1);
    end
  end

  // ---------------------------------------------------------------------------
  // Line input synchroniser
  // ---------------------------------------------------------------------------
  logic rxMeta_q, rxSync_q, rxLine;
  always_ff @(posedge clk) begin
    if (rst) begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
    end else begin
      rxMeta_q <= rxdIn;
      rxSync_q <= rxMeta_q;
    end
  end
  assign rxLine = ctrl1_q[enhanced_serial_if_pkg::C1_LOOP] ? txdOut : rxSync_q;

  // ---------------------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} enhanced_serial_if_tx_t;
  enhanced_serial_if_tx_t txState_q;
  logic [10:0] txShift_q;
  logic [3:0] txBits_q, txPh_q;
  logic txLoad, txParity, txOn;
  assign txOn = ctrl2_q[enhanced_serial_if_pkg::C2_TXEN] && ctrl1_q[enhanced_serial_if_pkg::C1_ENABLE];
  assign txLoad = txOn && txState_q == TX_IDLE && !txe_q;
  assign txParity = ^txData_q ^ (nine & tx9_q) ^ ctrl1_q[enhanced_serial_if_pkg::C1_PARODD];
  // Shift register holds start bit, data LSB first, then ninth or parity bit when used, then stop bit.
  logic [10:0] txFrame;
  always_comb begin
    txFrame = {2'b11, txData_q, 1'b0};
    if (nine) txFrame[9] = ctrl1_q[enhanced_serial_if_pkg::C1_PAREN] ? txParity : tx9_q;
    else if (ctrl1_q[enhanced_serial_if_pkg::C1_PAREN]) txFrame[9] = txParity;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      txState_q <= TX_IDLE;
      txShift_q <= '1;
      txBits_q <= '0;
      txPh_q <= '0;
    end else if (txLoad) begin
      txState_q <= TX_SHIFT;
      txShift_q <= txFrame;
      txBits_q <= (nine || ctrl1_q[enhanced_serial_if_pkg::C1_PAREN]) ? 4'hb : 4'ha;
      txPh_q <= '0;
    end else if (txState_q == TX_SHIFT && tick16) begin
      txPh_q <= txPh_q + 4'h1;
      if (txPh_q == 4'(enhanced_serial_if_pkg::OVERSAMPLE - 1)) begin
        txShift_q <= {1'b1, txShift_q[10:1]};
        txBits_q <= txBits_q - 4'h1;
        if (txBits_q == 4'h1) txState_q <= TX_IDLE;
      end
    end
  end
  logic txRaw;
  // Mark is high, space is low; inversion only flips polarity at the pin.
  assign txRaw = ctrl2_q[enhanced_serial_if_pkg::C2_BREAK] ? 1'b0
               : (txState_q == TX_SHIFT ? txShift_q[0] : 1'b1);
  always_ff @(posedge clk) begin
    if (rst) txdOut <= 1'b1;
    else txdOut <= txRaw ^ ctrl1_q[enhanced_serial_if_pkg::C1_TXINV];
  end

  // ---------------------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} enhanced_serial_if_rx_t;
  enhanced_serial_if_rx_t rxState_q;
  logic [3:0] rxPh_q, rxBits_q;
  logic [9:0] rxShift_q;
  logic [2:0] rxVote_q;
  logic rxNoise_q, rxDone, rxOn, rxBit, voteBad;
  assign rxOn = ctrl2_q[enhanced_serial_if_pkg::C2_RXEN] && ctrl1_q[enhanced_serial_if_pkg::C1_ENABLE];
  assign rxBit = (rxVote_q[0] & rxVote_q[1]) | (rxVote_q[1] & rxVote_q[2])
               | (rxVote_q[0] & rxVote_q[2]);
  assign voteBad = !(&rxVote_q) && (|rxVote_q);
  logic [3:0] rxLen;
  assign rxLen = (nine || ctrl1_q[enhanced_serial_if_pkg::C1_PAREN]) ? 4'ha : 4'h9;
  assign rxDone = rxState_q == RX_DATA && tick16 && rxPh_q == 4'(enhanced_serial_if_pkg::OVERSAMPLE_MID + 1)
                  && rxBits_q == rxLen - 4'h1;
  always_ff @(posedge clk) begin
    if (rst) begin
      rxState_q <= RX_IDLE;
      rxPh_q <= '0;
      rxBits_q <= '0;
      rxShift_q <= '0;
      rxVote_q <= '1;
      rxNoise_q <= 1'b0;
    end else if (!rxOn) begin
      rxState_q <= RX_IDLE;
    end else if (tick16) begin
      rxPh_q <= rxPh_q + 4'h1;
      if (rxPh_q >= 4'(enhanced_serial_if_pkg::OVERSAMPLE_MID - 2) && rxPh_q <= 4'(enhanced_serial_if_pkg::OVERSAMPLE_MID))
        rxVote_q <= {rxVote_q[1:0], rxLine};
      case (rxState_q)
        RX_IDLE: begin
          if (!rxLine) begin
            rxState_q <= RX_START;
            rxPh_q <= '0;
            rxNoise_q <= 1'b0;
          end
        end
        RX_START: begin
          if (rxPh_q == 4'(enhanced_serial_if_pkg::OVERSAMPLE_MID + 1)) begin
            if (rxBit) rxState_q <= RX_IDLE;
            else begin
              rxState_q <= RX_DATA;
              rxBits_q <= '0;
              rxNoise_q <= voteBad;
            end
          end
        end
        RX_DATA: begin
          if (rxPh_q == 4'(enhanced_serial_if_pkg::OVERSAMPLE_MID + 1)) begin
            rxShift_q <= {rxBit, rxShift_q[9:1]};
            rxBits_q <= rxBits_q + 4'h1;
            rxNoise_q <= rxNoise_q | voteBad;
            if (rxBits_q == rxLen - 4'h1) rxState_q <= RX_IDLE;
          end
        end
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end
  // At rxDone the stop bit is rxBit; data sits in rxShift_q aligned by frame length.
  logic [8:0] rxWord;
  assign rxWord = (rxLen == 4'ha) ? rxShift_q[9:1] : {rxShift_q[9], rxShift_q[9:2]};
  logic rxParBad;
  logic rxParSum;
  assign rxParSum = nine ? (^rxWord[8:0]) : (^rxWord[7:0] ^ rxShift_q[9]);
  assign rxParBad = ctrl1_q[enhanced_serial_if_pkg::C1_PAREN] && (rxParSum != ctrl1_q[enhanced_serial_if_pkg::C1_PARODD]);

  // ---------------------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------------------
  // Hardware set wins over a software clear in the same cycle, except for txe_q, which a data write clears.
  always_ff @(posedge clk) begin
    if (rst) begin
      {txe_q, tc_q, rxf_q, idle_q, or_q, nf_q, fe_q, pe_q} <= enhanced_serial_if_pkg::STATUS1_RESET;
      txData_q <= '0;
    end else begin
      if (wrData) begin
        txData_q <= regWdata;
        txe_q <= 1'b0;
        tc_q <= 1'b0;
      end else if (txLoad) txe_q <= 1'b1;
      if (txState_q == TX_SHIFT && tick16 && txPh_q == 4'(enhanced_serial_if_pkg::OVERSAMPLE - 1)
          && txBits_q == 4'h1 && txe_q) tc_q <= 1'b1;
      if (rxDone) begin
        rxf_q <= 1'b1;
        or_q <= rxf_q;
        nf_q <= rxNoise_q | voteBad;
        fe_q <= !rxBit;
        pe_q <= rxParBad;
      end else if (rdData) begin
        {rxf_q, or_q, nf_q, fe_q, pe_q} <= '0;
      end
      idle_q <= rxState_q == RX_IDLE && rxOn && !rxf_q;
    end
  end
  always_ff @(posedge clk) begin
    if (rxDone && !rxf_q) begin
      rxData_q <= nine ? rxWord[7:0] : rxWord[7:0];
      rx9_q <= nine ? rxWord[8] : rxWord[7];
    end
  end

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      presc_q <= enhanced_serial_if_pkg::CTRL_RESET;
      ctrl1_q <= enhanced_serial_if_pkg::CTRL_RESET;
      ctrl2_q <= enhanced_serial_if_pkg::CTRL_RESET;
      baud_q <= enhanced_serial_if_pkg::CTRL_RESET;
      tx9_q <= 1'b0;
      irqEn_q <= '0;
      evtEn_q <= '0;
    end else if (regWr) begin
      case (regAddr)
        enhanced_serial_if_pkg::ADDR_PRESCALER: presc_q <= regWdata;
        enhanced_serial_if_pkg::ADDR_CTRL1: ctrl1_q <= regWdata;
        enhanced_serial_if_pkg::ADDR_CTRL2: ctrl2_q <= regWdata;
        enhanced_serial_if_pkg::ADDR_BAUD: baud_q <= regWdata;
        enhanced_serial_if_pkg::ADDR_CTRL3: begin
          tx9_q <= regWdata[enhanced_serial_if_pkg::C3_TX9];
          irqEn_q <= {2'b00, regWdata[3:0]};
        end
        enhanced_serial_if_pkg::ADDR_EVT_ENABLE: evtEn_q <= regWdata[2:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  assign errIrq = (or_q & irqEn_q[enhanced_serial_if_pkg::C3_OVR_EN]) | (nf_q & irqEn_q[enhanced_serial_if_pkg::C3_NOISE_EN])
                | (fe_q & irqEn_q[enhanced_serial_if_pkg::C3_FRAME_EN])
                | (pe_q & irqEn_q[enhanced_serial_if_pkg::C3_PAR_EN]);
  logic tcPrev_q;
  logic [2:0] evtSet;
  assign evtSet = {errIrq, tc_q & ~tcPrev_q, rxDone};
  always_ff @(posedge clk) begin
    if (rst) begin
      evt_q <= '0;
      tcPrev_q <= 1'b1;
    end else begin
      tcPrev_q <= tc_q;
      evt_q <= (evt_q & ~(wrClr ? regWdata[2:0] : 3'h0)) | evtSet;
    end
  end
  assign irq = |(evt_q & evtEn_q);

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic [7:0] rdMux;
  always_comb begin
    case (regAddr)
      enhanced_serial_if_pkg::ADDR_PRESCALER: rdMux = presc_q;
      enhanced_serial_if_pkg::ADDR_CTRL1: rdMux = ctrl1_q;
      enhanced_serial_if_pkg::ADDR_CTRL2: rdMux = ctrl2_q;
      enhanced_serial_if_pkg::ADDR_CTRL3: rdMux = {rx9_q, tx9_q, 2'b00, irqEn_q[3:0]};
      enhanced_serial_if_pkg::ADDR_STATUS1: rdMux = {txe_q, tc_q, rxf_q, idle_q, or_q, nf_q, fe_q, pe_q};
      enhanced_serial_if_pkg::ADDR_DATA: rdMux = rxData_q;
      enhanced_serial_if_pkg::ADDR_BAUD: rdMux = baud_q;
      enhanced_serial_if_pkg::ADDR_EVT_STATUS: rdMux = {5'h00, evt_q};
      enhanced_serial_if_pkg::ADDR_EVT_ENABLE: rdMux = {5'h00, evtEn_q};
      default: rdMux = 8'h00;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) rdata_q <= '0;
    else if (regRd) rdata_q <= rdMux;
  end
  assign regRdata = rdata_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_err_gate: assert property (@(posedge clk) disable iff (rst)
    (or_q && irqEn_q[3]) |-> errIrq) else $error("overrun not gated");
  chk_noise_gate: assert property (@(posedge clk) disable iff (rst)
    (nf_q && irqEn_q[2]) |-> errIrq) else $error("noise not gated");
  chk_frame_gate: assert property (@(posedge clk) disable iff (rst)
    (fe_q && irqEn_q[1]) |-> errIrq) else $error("framing not gated");
  chk_par_gate: assert property (@(posedge clk) disable iff (rst)
    (pe_q && irqEn_q[0]) |-> errIrq) else $error("parity not gated");
  chk_err_quiet: assert property (@(posedge clk) disable iff (rst)
    (irqEn_q[3:0] == 4'h0) |-> !errIrq) else $error("error irq without enable");
  chk_reset_status: assert property (@(posedge clk) $past(rst) |->
    txe_q && tc_q && !rxf_q && !or_q && !fe_q) else $error("bad status after reset");
  chk_tx9_reset: assert property (@(posedge clk) $past(rst) |-> !tx9_q)
    else $error("tx ninth bit not cleared");
  chk_rx9_copy: assert property (@(posedge clk) disable iff (rst)
    (rxDone && !rxf_q && !nine) |=> rx9_q == rxData_q[7]) else $error("rx bit copy wrong");
  chk_tx_load: assert property (@(posedge clk) disable iff (rst)
    (txLoad && nine && !ctrl1_q[1]) |=> txShift_q[9] == $past(tx9_q))
    else $error("tx9 not loaded");
  cov_rx_done: cover property (@(posedge clk) rxDone);
  cov_tx_load: cover property (@(posedge clk) txLoad);
  cov_err_irq: cover property (@(posedge clk) errIrq);
endmodule : enhanced_serial_if_core
`default_nettype wire

// ===== enhanced_serial_if_pkg.sv
// Package with register map, field positions, reset values and timing for the serial block.
// -----------------------------------------------------------------------------
// Overview of operation
// - In 9-bit mode the ninth received bit reads as a read-only bit of control register three.
// - The received ninth bit is captured in the same cycle as the other eight received data bits.
// - In 8-bit mode the received ninth bit field holds a copy of received bit 7.
// - The received ninth bit is not touched by reset.
// - In 9-bit transmit mode with parity off a software read/write bit supplies bit 8 of each sent character.
// - The transmit ninth bit enters the shift register in the same transfer as the data byte.
// - Reset clears the transmit ninth bit.
// - The overrun enable, cleared by reset, gates the overrun flag onto the error interrupt.
// - The noise enable, cleared by reset, gates the noise flag onto the error interrupt.
// - The framing enable, cleared by reset, gates the framing flag onto the error interrupt.
// - The parity enable, cleared by reset, gates the parity flag onto the error interrupt.
// - After reset status one reads transmit-empty and complete set, all other flags clear.
// - Every character on the line uses non-return-to-zero mark/space framing in both directions.
// - The baud clock comes from one of two sources picked by a select input outside the block.
// -----------------------------------------------------------------------------
package enhanced_serial_if_pkg;
  localparam logic [4:0] ADDR_PRESCALER = 5'h09;
  localparam logic [4:0] ADDR_ARB_CTRL = 5'h0a;
  localparam logic [4:0] ADDR_ARB_DATA = 5'h0b;
  localparam logic [4:0] ADDR_CTRL1 = 5'h13;
  localparam logic [4:0] ADDR_CTRL2 = 5'h14;
  localparam logic [4:0] ADDR_CTRL3 = 5'h15;
  localparam logic [4:0] ADDR_STATUS1 = 5'h16;
  localparam logic [4:0] ADDR_STATUS2 = 5'h17;
  localparam logic [4:0] ADDR_DATA = 5'h18;
  localparam logic [4:0] ADDR_BAUD = 5'h19;
  localparam logic [4:0] ADDR_EVT_STATUS = 5'h1a;
  localparam logic [4:0] ADDR_EVT_CLEAR = 5'h1b;
  localparam logic [4:0] ADDR_EVT_ENABLE = 5'h1c;
  // Control one fields.
  localparam int C1_LOOP = 7;
  localparam int C1_ENABLE = 6;
  localparam int C1_TXINV = 5;
  localparam int C1_NINE = 4;
  localparam int C1_PAREN = 1;
  localparam int C1_PARODD = 0;
  // Control two fields.
  localparam int C2_TXEN = 3;
  localparam int C2_RXEN = 2;
  localparam int C2_BREAK = 0;
  // Control three fields.
  localparam int C3_RX9 = 7;
  localparam int C3_TX9 = 6;
  localparam int C3_OVR_EN = 3;
  localparam int C3_NOISE_EN = 2;
  localparam int C3_FRAME_EN = 1;
  localparam int C3_PAR_EN = 0;
  // Status one fields.
  localparam int S1_TXE = 7;
  localparam int S1_DONE = 6;
  localparam int S1_RXF = 5;
  localparam int S1_IDLE = 4;
  localparam int S1_OR = 3;
  localparam int S1_NOISE = 2;
  localparam int S1_FRAME = 1;
  localparam int S1_PAR = 0;
  localparam logic [7:0] STATUS1_RESET = 8'hc0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int OVERSAMPLE = 16;
  localparam int OVERSAMPLE_MID = 8;
  // Event bits of the interrupt status register.
  localparam int EV_RXF = 0;
  localparam int EV_TC = 1;
  localparam int EV_ERR = 2;
  localparam int EV_W = 3;
endpackage : enhanced_serial_if_pkg

// ===== enhanced_serial_if_line_node.sv
// Remote serial node model that drives and captures characters on the line.
`timescale 1ns/1ps
`default_nettype none
module enhanced_serial_if_line_node (
  // Clock.
  input wire logic clk,
  // Serial line.
  output logic lineOut,
  input wire logic lineIn
);
  initial lineOut = 1'b1;

  // Start low, data LSB first, stop high (low when bs is set); a glitch flips one tick mid bit 3.
  task automatic sendFrame(input logic [8:0] d, input int nb, input int per,
      input logic bs, input logic gl);
    lineOut <= 1'b0;
    repeat (per) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      lineOut <= d[i];
      if (gl && i == 3) begin
        repeat (per / 2) @(posedge clk);
        lineOut <= ~d[i];
        @(posedge clk);
        lineOut <= d[i];
        repeat (per / 2 - 1) @(posedge clk);
      end else begin
        repeat (per) @(posedge clk);
      end
    end
    lineOut <= ~bs;
    repeat (per) @(posedge clk);
    lineOut <= 1'b1;
    repeat (2 * per) @(posedge clk);
  endtask : sendFrame

  // Samples each bit at its middle; f[nb] holds the stop bit.
  task automatic captureFrame(output logic [9:0] f, input int nb, input int per);
    f = '1;
    @(negedge lineIn);
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i <= nb; i++) begin
      repeat (per) @(posedge clk);
      f[i] = lineIn;
    end
  endtask : captureFrame
endmodule : enhanced_serial_if_line_node
`default_nettype wire

// ===== enhanced_serial_if_core_tb.sv
// Self-checking testbench of the serial interface core.
`timescale 1ns/1ps
`default_nettype none
module enhanced_serial_if_core_tb;
  logic clk, rst, regWr, regRd, baudSrcSelect, altTickIn, rxdIn, txdOut, errIrq, irq;
  logic [4:0] regAddr;
  logic [7:0] regWdata, regRdata, v;
  logic [8:0] d;
  logic [9:0] f;
  logic [31:0] rngState = 32'h0000610a;
  int nErrors = 0;
  int samplesChecked = 0;
  int cycles = 0;

  enhanced_serial_if_core uut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .baudSrcSelect(baudSrcSelect),
    .altTickIn(altTickIn), .rxdIn(rxdIn), .txdOut(txdOut), .errIrq(errIrq), .irq(irq));
  enhanced_serial_if_line_node partner (.clk(clk), .lineOut(rxdIn), .lineIn(txdOut));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // The alternate baud source ticks every second cycle.
  always @(posedge clk) altTickIn <= ~altTickIn;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 60000) begin
      nErrors++;
      printVerdict();
    end
  end

  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic [31:0] nextRand();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction : nextRand

  function automatic logic rx9Expect(input logic [8:0] x, input logic nine);
    return nine ? x[8] : x[7];
  endfunction : rx9Expect

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [7:0] w);
    @(posedge clk);
    regAddr <= a;
    regWdata <= w;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] r);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    r = regRdata;
  endtask : rd

  task automatic rxFrame(input int nb, input logic nine);
    d = 9'(nextRand());
    partner.sendFrame(d, nb, 16, 1'b0, 1'b0);
    rd(enhanced_serial_if_pkg::ADDR_DATA, v);
    check(v, d[7:0]);
    rd(enhanced_serial_if_pkg::ADDR_CTRL3, v);
    check({7'h0, v[7]}, {7'h0, rx9Expect(d, nine)});
  endtask : rxFrame

  // Raises one error flag, then checks that it reaches errIrq only once its enable is set.
  task automatic errCase(input logic [7:0] c1, input int nb, input logic bs, input logic gl,
      input int nSend, input int pos);
    d = 9'(nextRand());
    d[8] = ~(^d[7:0]);
    wr(enhanced_serial_if_pkg::ADDR_CTRL1, c1);
    repeat (nSend) partner.sendFrame(d, nb, 16, bs, gl);
    rd(enhanced_serial_if_pkg::ADDR_STATUS1, v);
    check({7'h0, v[pos]}, 8'h01);
    check({7'h0, errIrq}, 8'h00);
    wr(enhanced_serial_if_pkg::ADDR_CTRL3, 8'h01 << pos);
    check({7'h0, errIrq}, 8'h01);
    rd(enhanced_serial_if_pkg::ADDR_DATA, v);
    check({7'h0, errIrq}, 8'h00);
    wr(enhanced_serial_if_pkg::ADDR_CTRL3, 8'h00);
    repeat (250) @(posedge clk);
    rd(enhanced_serial_if_pkg::ADDR_DATA, v);
    $display("test error flag %0d done", pos);
  endtask : errCase

  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : printVerdict

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 5'h00;
    regWdata = 8'h00;
    baudSrcSelect = 1'b0;
    altTickIn = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(enhanced_serial_if_pkg::ADDR_STATUS1, v);
    check(v, 8'hc0);
    rd(enhanced_serial_if_pkg::ADDR_CTRL3, v);
    check(v & 8'h7f, 8'h00);
    rd(5'h1f, v);
    check(v, 8'h00);
    $display("test reset values done");
    wr(enhanced_serial_if_pkg::ADDR_CTRL1, 8'h50);
    wr(enhanced_serial_if_pkg::ADDR_CTRL2, 8'h0c);
    for (int k = 0; k < 4; k++) begin
      d = 9'(nextRand());
      baudSrcSelect <= (k == 3);
      wr(enhanced_serial_if_pkg::ADDR_CTRL3, {1'b0, d[8], 6'h00});
      fork
        partner.captureFrame(f, 9, (k == 3) ? 32 : 16);
        begin
          wr(enhanced_serial_if_pkg::ADDR_DATA, d[7:0]);
          wait (txdOut === 1'b0);
          wr(enhanced_serial_if_pkg::ADDR_CTRL3, {1'b0, ~d[8], 6'h00});
        end
      join
      check({7'h0, f[8]}, {7'h0, d[8]});
      check(f[7:0], d[7:0]);
      check({7'h0, f[9]}, 8'h01);
      repeat (40) @(posedge clk);
    end
    baudSrcSelect <= 1'b0;
    $display("test nine bit transmit done");
    for (int k = 0; k < 3; k++) rxFrame(9, 1'b1);
    wr(enhanced_serial_if_pkg::ADDR_CTRL3, 8'h40);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(enhanced_serial_if_pkg::ADDR_CTRL3, v);
    check({7'h0, v[7]}, {7'h0, d[8]});
    check({7'h0, v[6]}, 8'h00);
    $display("test reset retention done");
    wr(enhanced_serial_if_pkg::ADDR_CTRL1, 8'h40);
    wr(enhanced_serial_if_pkg::ADDR_CTRL2, 8'h0c);
    for (int k = 0; k < 3; k++) rxFrame(8, 1'b0);
    rd(enhanced_serial_if_pkg::ADDR_EVT_STATUS, v);
    check({7'h0, v[0]}, 8'h01);
    check({7'h0, irq}, 8'h00);
    wr(enhanced_serial_if_pkg::ADDR_EVT_ENABLE, 8'h01);
    check({7'h0, irq}, 8'h01);
    wr(enhanced_serial_if_pkg::ADDR_EVT_CLEAR, 8'h01);
    check({7'h0, irq}, 8'h00);
    $display("test receive and events done");
    errCase(8'h40, 8, 1'b1, 1'b0, 1, enhanced_serial_if_pkg::S1_FRAME);
    errCase(8'h42, 9, 1'b0, 1'b0, 1, enhanced_serial_if_pkg::S1_PAR);
    errCase(8'h40, 8, 1'b0, 1'b1, 1, enhanced_serial_if_pkg::S1_NOISE);
    errCase(8'h40, 8, 1'b0, 1'b0, 2, enhanced_serial_if_pkg::S1_OR);
    printVerdict();
  end
endmodule : enhanced_serial_if_core_tb
`default_nettype wire
